/* File: src/qdp_pkg.sv */
package qdp_pkg;
  localparam int unsigned POTS = 4;
  localparam int unsigned REGS = 4;
  localparam int unsigned WIPER_W = 6;
  localparam int unsigned TAPS = 64;
  localparam int unsigned SEGMENTS = 63;
  // Identification byte layout.
  localparam logic [3:0] DEV_TYPE = 4'h5;
  localparam logic [1:0] ID_PAD = 2'h0;
  localparam int unsigned TYPE_LO = 4;
  localparam int unsigned PAD_LO = 2;
  // Instruction byte layout.
  localparam int unsigned OP_LO = 4;
  localparam int unsigned REG_LO = 2;
  localparam int unsigned POT_LO = 0;
  // Operation codes.
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_STORE = 4'hB;
  localparam logic [3:0] OP_WR_STORE = 4'hC;
  localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_XFR_TO_STORE = 4'hE;
  localparam logic [3:0] OP_GXFR_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_GXFR_TO_STORE = 4'h8;
  localparam logic [3:0] OP_RD_STATUS = 4'h5;
  // Reset values.
  localparam logic [5:0] WIPER_RST = 6'h00;
  localparam logic [5:0] STORE_RST = 6'h00;
  // Nonvolatile save time: longest time in microseconds, clock in MHz.
  localparam int unsigned NV_SAVE_US = 10000;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned NV_SAVE_CYC = NV_SAVE_US * CLK_MHZ;
  localparam int unsigned BUSY_W = 21;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ID = 5'h02,
    ST_INSTR = 5'h04,
    ST_DATA = 5'h08,
    ST_DONE = 5'h10
  } qdp_state_e;
endpackage

/* File: src/qdp_tap_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module qdp_tap_decode
  import qdp_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [POTS*WIPER_W-1:0] wiper_i,
  output logic [POTS*TAPS-1:0] tap_sel_o
);
  logic [POTS*TAPS-1:0] tap_d;

  // Exactly one of the 64 taps between the 63 segments is closed per pot.
  always_comb begin
    tap_d = '0;
    for (int p = 0; p < POTS; p++) begin
      tap_d[p*TAPS + int'(wiper_i[p*WIPER_W +: WIPER_W])] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tap_sel_o <= '0;
    end else begin
      tap_sel_o <= tap_d;
    end
  end

  a_tap_onehot: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> $onehot(tap_sel_o[TAPS-1:0]) && $onehot(tap_sel_o[2*TAPS-1:TAPS]))
    else $error("Tap select is not one-hot.");
endmodule
`default_nettype wire

/* File: src/qdp_serial_ctrl.sv */
// Behaviour
// - Each pot has 63 segments and 64 taps.
// - Per pot one wiper and four stored settings.
// - Wiper register value selects the closed tap.
// - Power-up loads wiper from stored setting zero.
// - Read data changes on serial clock falling.
// - Input bits captured on serial clock rising.
// - Select high releases output, standby unless saving.
// - Select low enables device, active power mode.
// - Command needs select falling edge after power-up; select syncs reset high, so one held low still opens a frame.
// - Pause input freezes sequence without resetting it.
// - Straps give identification byte's two low bits.
// - Respond only when serial address matches straps.
// - Write protect low blocks nonvolatile writes.
// - Six-bit wiper decoded to one of 64.
// - Instruction byte: operation, register, pot fields.
// - Save starts at select rise; busy flag readable.
`timescale 1ns/1ps
`default_nettype none
module qdp_serial_ctrl
  import qdp_pkg::*;
#(
  parameter int unsigned NV_SAVE_CYCLES = NV_SAVE_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic [1:0] strap_address_inputs_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic active_o,
  output logic standby_o,
  output logic nv_save_busy_flag_o,
  output logic [POTS*WIPER_W-1:0] wiper_position_reg_o,
  output logic [POTS*TAPS-1:0] tap_sel_o
);
  // Pin synchronisers: the first stage is read only by the second.
  logic [5:0] sync_m_q;
  logic [5:0] sync_q;
  logic [1:0] strap_m_q;
  logic [1:0] strap_q;
  logic sck_p_q;
  logic cs_p_q;
  logic sck_q, cs_q, si_q, hold_q, wp_q;

  logic [5:0] wiper_position_reg [POTS];
  logic [5:0] stored_setting_regs [POTS][REGS];
  qdp_state_e st_q, st_d;
  logic [2:0] bitcnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [3:0] op_q;
  logic [1:0] reg_q, pot_q;
  logic pend_q;
  logic [3:0] pend_op_q;
  logic [1:0] pend_reg_q, pend_pot_q;
  logic [5:0] pend_data_q;
  logic [BUSY_W-1:0] busy_q;
  logic recall_q;

  assign sck_q = sync_q[0];
  assign cs_q = sync_q[1];
  assign si_q = sync_q[2];
  assign hold_q = sync_q[3];
  assign wp_q = sync_q[4];

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync_m_q <= 6'h1A;
      sync_q <= 6'h1A;
      strap_m_q <= 2'h0;
      strap_q <= 2'h0;
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else begin
      sync_m_q <= {1'b0, wp_n_i, hold_n_i, si_i, cs_n_i, sck_i};
      sync_q <= sync_m_q;
      strap_m_q <= strap_address_inputs_i;
      strap_q <= strap_m_q;
      sck_p_q <= sck_q;
      cs_p_q <= cs_q;
    end
  end

  wire sck_rise = sck_q & ~sck_p_q;
  wire sck_fall = ~sck_q & sck_p_q;
  wire cs_fall = cs_p_q & ~cs_q;
  wire cs_rise = ~cs_p_q & cs_q;
  wire in_frame = (st_q == ST_ID) || (st_q == ST_INSTR) || (st_q == ST_DATA);
  // A paused sequence ignores clock edges; its bit count stays put.
  wire take = sck_rise & hold_q & ~cs_q & in_frame;
  wire [7:0] rx_next = {rx_q[6:0], si_q};
  wire byte_done = take && (bitcnt_q == 3'h7);
  wire [3:0] new_op = rx_next[7:OP_LO];
  wire [1:0] new_reg = rx_next[REG_LO +: 2];
  wire [1:0] new_pot = rx_next[POT_LO +: 2];
  // Type, zero pad and the strapped address must all match.
  wire id_match = (rx_next[7:TYPE_LO] == DEV_TYPE) && (rx_next[PAD_LO +: 2] == ID_PAD)
                  && (rx_next[1:0] == strap_q);
  wire three_byte = (new_op == OP_RD_WIPER) || (new_op == OP_WR_WIPER)
                    || (new_op == OP_RD_STORE) || (new_op == OP_WR_STORE)
                    || (new_op == OP_RD_STATUS);
  wire is_read = (op_q == OP_RD_WIPER) || (op_q == OP_RD_STORE) || (op_q == OP_RD_STATUS);
  wire instr_done = byte_done && (st_q == ST_INSTR);
  wire data_done = byte_done && (st_q == ST_DATA);
  wire nv_busy = (busy_q != '0);
  // A save is started only from a complete write and never while protected.
  wire commit = cs_rise && pend_q && wp_q && !nv_busy;
  wire to_store = (new_op == OP_XFR_TO_STORE) || (new_op == OP_GXFR_TO_STORE);

  // Reset parks the machine in ST_DONE, which only a high select leaves; the synchronised select
  // also resets high, so a select held low through power-up still yields a falling edge and opens a frame.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (cs_fall) begin
          st_d = ST_ID;
        end
      end
      ST_ID: begin
        if (byte_done) begin
          st_d = id_match ? ST_INSTR : ST_DONE;
        end
      end
      ST_INSTR: begin
        if (byte_done) begin
          st_d = three_byte ? ST_DATA : ST_DONE;
        end
      end
      ST_DATA: begin
        if (byte_done) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: st_d = ST_DONE;
      default: st_d = ST_IDLE;
    endcase
    if (cs_q) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= ST_DONE;
      bitcnt_q <= 3'h0;
      rx_q <= 8'h00;
      op_q <= 4'h0;
      reg_q <= 2'h0;
      pot_q <= 2'h0;
    end else begin
      st_q <= st_d;
      if (take) begin
        rx_q <= rx_next;
      end
      if (cs_q || (st_q == ST_IDLE)) begin
        bitcnt_q <= 3'h0;
      end else if (take) begin
        bitcnt_q <= bitcnt_q + 3'h1;
      end
      if (instr_done) begin
        op_q <= new_op;
        reg_q <= new_reg;
        pot_q <= new_pot;
      end
    end
  end

  // Read data leaves MSB first, moving only on a falling clock edge.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_q <= 8'h00;
      so_o <= 1'b0;
    end else if (instr_done) begin
      case (new_op)
        OP_RD_WIPER: tx_q <= {2'h0, wiper_position_reg[new_pot]};
        OP_RD_STORE: tx_q <= {2'h0, stored_setting_regs[new_pot][new_reg]};
        OP_RD_STATUS: tx_q <= {7'h00, nv_busy};
        default: tx_q <= 8'h00;
      endcase
    end else if (sck_fall && hold_q && !cs_q && (st_q == ST_DATA) && is_read) begin
      so_o <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // The output is released while deselected or paused, so a shared bus stays free.
  assign so_oe_n_o = ~((st_q == ST_DATA) && is_read && !cs_q && hold_q);

  // Nonvolatile writes are queued until select rises; a cut frame queues nothing.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pend_q <= 1'b0;
      pend_op_q <= 4'h0;
      pend_reg_q <= 2'h0;
      pend_pot_q <= 2'h0;
      pend_data_q <= 6'h00;
    end else if (cs_rise) begin
      pend_q <= 1'b0;
    end else if (instr_done && to_store) begin
      pend_q <= 1'b1;
      pend_op_q <= new_op;
      pend_reg_q <= new_reg;
      pend_pot_q <= new_pot;
    end else if (data_done && (op_q == OP_WR_STORE)) begin
      pend_q <= 1'b1;
      pend_op_q <= op_q;
      pend_reg_q <= reg_q;
      pend_pot_q <= pot_q;
      pend_data_q <= rx_next[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_q <= '0;
    end else if (commit) begin
      busy_q <= BUSY_W'(NV_SAVE_CYCLES);
    end else if (nv_busy) begin
      busy_q <= busy_q - BUSY_W'(1);
    end
  end

  // Stored settings take their reset value on power-up; nonvolatility is modelled
  // only through the save time, since the array has no retention of its own.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      recall_q <= 1'b1;
      for (int p = 0; p < POTS; p++) begin
        wiper_position_reg[p] <= WIPER_RST;
        for (int r = 0; r < REGS; r++) begin
          stored_setting_regs[p][r] <= STORE_RST;
        end
      end
    end else begin
      recall_q <= 1'b0;
      for (int p = 0; p < POTS; p++) begin
        if (recall_q) begin
          wiper_position_reg[p] <= stored_setting_regs[p][0];
        end else if (instr_done && (new_op == OP_GXFR_TO_WIPER)) begin
          wiper_position_reg[p] <= stored_setting_regs[p][new_reg];
        end else if (instr_done && (new_op == OP_XFR_TO_WIPER) && (new_pot == 2'(p))) begin
          wiper_position_reg[p] <= stored_setting_regs[p][new_reg];
        end else if (data_done && (op_q == OP_WR_WIPER) && (pot_q == 2'(p))) begin
          wiper_position_reg[p] <= rx_next[5:0];
        end
        if (commit) begin
          for (int r = 0; r < REGS; r++) begin
            if (pend_reg_q == 2'(r)) begin
              if (pend_op_q == OP_GXFR_TO_STORE) begin
                stored_setting_regs[p][r] <= wiper_position_reg[p];
              end else if ((pend_pot_q == 2'(p)) && (pend_op_q == OP_XFR_TO_STORE)) begin
                stored_setting_regs[p][r] <= wiper_position_reg[p];
              end else if ((pend_pot_q == 2'(p)) && (pend_op_q == OP_WR_STORE)) begin
                stored_setting_regs[p][r] <= pend_data_q;
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      active_o <= 1'b0;
      standby_o <= 1'b1;
    end else begin
      active_o <= ~cs_q;
      standby_o <= cs_q & ~nv_busy;
    end
  end

  assign nv_save_busy_flag_o = nv_busy;
  for (genvar g = 0; g < POTS; g++) begin : g_wiper
    assign wiper_position_reg_o[g*WIPER_W +: WIPER_W] = wiper_position_reg[g];
  end

  qdp_tap_decode u_tap (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wiper_i(wiper_position_reg_o),
    .tap_sel_o(tap_sel_o)
  );

  wire [POTS*REGS*WIPER_W-1:0] store_flat;
  for (genvar g = 0; g < POTS*REGS; g++) begin : g_flat
    assign store_flat[g*WIPER_W +: WIPER_W] = stored_setting_regs[g/REGS][g%REGS];
  end

  sequence s_commit;
    cs_rise && pend_q && wp_q && !nv_busy;
  endsequence

  a_so_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_q |-> so_oe_n_o)
    else $error("Serial output driven while deselected.");
  a_active_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cs_q |=> active_o && !standby_o)
    else $error("Selected device not in active mode.");
  a_need_fall: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_IDLE) && !cs_fall |=> (st_q == ST_IDLE))
    else $error("Frame opened without select falling edge.");
  a_rise_capture: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !sck_rise |=> $stable(rx_q))
    else $error("Input captured away from rising clock edge.");
  a_fall_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(so_o) |-> $past(sck_fall))
    else $error("Output bit changed away from falling clock edge.");
  a_hold_freeze: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !hold_q && !cs_q && in_frame |=> cs_q || ($stable(bitcnt_q) && $stable(rx_q)))
    else $error("Sequence advanced while paused.");
  a_addr_reject: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_ID) && byte_done && !id_match |=> so_oe_n_o throughout (st_q == ST_DONE)[*2])
    else $error("Device answered a foreign address.");
  a_recall_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    recall_q |=> wiper_position_reg[0] == $past(stored_setting_regs[0][0])
                 && wiper_position_reg[3] == $past(stored_setting_regs[3][0]))
    else $error("Power-up recall did not load stored setting zero.");
  a_wp_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !wp_q |=> $stable(store_flat))
    else $error("Stored setting changed while write protected.");
  a_save_busy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_commit |=> nv_save_busy_flag_o [*2])
    else $error("Save did not raise the busy flag.");
  a_partial_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_rise && !pend_q |=> $stable(store_flat))
    else $error("Partial command changed a stored setting.");
endmodule
`default_nettype wire

/* File: testbench/qdp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module qdp_host (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  int pause_at = -1;
  int bit_n;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Six system clocks per serial phase, above the two the synchronisers need.
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    for (int i = 7; i > 7 - nb; i--) begin
      si_o <= tx[i];
      if (bit_n == pause_at) begin
        tick(3);
        hold_n_o <= 1'b0;
        tick(6);
        // A stray clock pulse while paused must not be taken as a bit.
        sck_o <= 1'b1;
        tick(6);
        sck_o <= 1'b0;
        tick(8);
        hold_n_o <= 1'b1;
      end
      tick(6);
      sck_o <= 1'b1;
      rx[i] = so_i;
      tick(6);
      sck_o <= 1'b0;
      bit_n++;
    end
  endtask
  task automatic frame(input logic [7:0] id, input logic [7:0] ins, input logic [7:0] dat,
                       input int nb, output logic [7:0] rd);
    logic [7:0] dump;
    bit_n = 0;
    cs_n_o <= 1'b0;
    tick(6);
    xfer(id, 8, dump);
    xfer(ins, 8, dump);
    if (nb > 0) begin
      xfer(dat, nb, rd);
    end
    tick(6);
    cs_n_o <= 1'b1;
    // A released line must not keep looking like valid data.
    si_o <= ~si_o;
    tick(6);
  endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import qdp_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic [1:0] strap = 2'h0;
  wire logic sck, cs_n, si, hold_n, so, so_oe_n, active, standby, busy;
  // A released output reads as the inverse of its last bit, so a missing enable shows up.
  wire logic so_line = so_oe_n ? ~so : so;
  wire logic [POTS*WIPER_W-1:0] wiper;
  wire logic [POTS*TAPS-1:0] taps;
  logic [7:0] rd;
  int failures = 0;
  int comparisons = 0;
  qdp_serial_ctrl #(.NV_SAVE_CYCLES(400)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n_i), .strap_address_inputs_i(strap), .so_o(so),
    .so_oe_n_o(so_oe_n), .active_o(active), .standby_o(standby),
    .nv_save_busy_flag_o(busy), .wiper_position_reg_o(wiper), .tap_sel_o(taps));
  qdp_host host (.clk_i(clk_i), .so_i(so_line), .sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .hold_n_o(hold_n));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out();
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    host.tick(4);
    `CHK(wiper, 24'h000000)
    `CHK(taps, {4{64'h1}})
    `CHK({standby, active, so_oe_n}, 3'h5)
  endtask
  task automatic t_wiper();
    host.frame(8'h50, {OP_WR_WIPER, 4'h1}, 8'h2A, 8, rd);
    `CHK(wiper[11:6], 6'h2A)
    `CHK(taps[127:64], 64'h1 << 42)
  endtask
  task automatic t_store();
    host.frame(8'h50, {OP_WR_STORE, 4'hE}, 8'h15, 8, rd);
    `CHK(busy, 1'b1)
    `CHK(standby, 1'b0)
    host.frame(8'h50, {OP_RD_STATUS, 4'h0}, 8'hFF, 8, rd);
    `CHK(rd, 8'h01)
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk_i);
    host.frame(8'h50, {OP_RD_STORE, 4'hE}, 8'hFF, 8, rd);
    `CHK(rd, 8'h15)
    host.frame(8'h50, {OP_XFR_TO_WIPER, 4'hE}, 8'h00, 0, rd);
    `CHK(wiper[17:12], 6'h15)
  endtask
  task automatic t_protect();
    wp_n_i <= 1'b0;
    host.frame(8'h50, {OP_WR_STORE, 4'h4}, 8'h33, 8, rd);
    `CHK(busy, 1'b0)
    wp_n_i <= 1'b1;
    host.frame(8'h50, {OP_RD_STORE, 4'h4}, 8'hFF, 8, rd);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_address();
    strap <= 2'h1;
    host.frame(8'h50, {OP_WR_WIPER, 4'h0}, 8'h3F, 8, rd);
    `CHK(wiper[5:0], 6'h00)
    host.frame(8'h51, {OP_WR_WIPER, 4'h0}, 8'h3F, 8, rd);
    `CHK(wiper[5:0], 6'h3F)
    strap <= 2'h0;
  endtask
  task automatic t_partial();
    host.frame(8'h50, {OP_WR_WIPER, 4'h3}, 8'h11, 5, rd);
    `CHK(wiper[23:18], 6'h00)
  endtask
  task automatic t_hold();
    host.pause_at = 10;
    host.frame(8'h50, {OP_WR_WIPER, 4'h0}, 8'h07, 8, rd);
    `CHK(wiper[5:0], 6'h07)
    host.pause_at = -1;
  endtask
  task automatic t_transfer();
    host.frame(8'h50, {OP_GXFR_TO_STORE, 4'h8}, 8'h00, 0, rd);
    host.frame(8'h50, {OP_WR_WIPER, 4'h0}, 8'h3C, 8, rd);
    host.frame(8'h50, {OP_GXFR_TO_WIPER, 4'h8}, 8'h00, 0, rd);
    `CHK(wiper, 24'h015A87)
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk_i);
    host.frame(8'h50, {OP_XFR_TO_STORE, 4'h5}, 8'h00, 0, rd);
    host.frame(8'h50, {OP_RD_STORE, 4'h5}, 8'hFF, 8, rd);
    `CHK(rd, 8'h2A)
    host.frame(8'h50, {OP_RD_WIPER, 4'h1}, 8'hFF, 8, rd);
    `CHK(rd, 8'h2A)
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_wiper();
    t_store();
    t_protect();
    t_address();
    t_partial();
    t_hold();
    t_transfer();
    close_out();
  end
  // The sequence needs about 5000 clocks; four times that means a hang.
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
